/* File: bench/vc_chan_model.sv */
// Purpose: Stand-in for the channel buffers and the framing layer.
// Assumes: Each load of the ready mask gives every marked channel one frame.
// Notes: A granted frame ends five cycles after grantValid with one lastWord pulse.
`timescale 1ns/10ps
`default_nettype none
module vc_chan_model
  import vc_arb_pkg::*;
(
  // Clock, cold reset and bench control.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [NUM_VC-1:0] newReady,
  input wire logic [LEN_W-1:0] frameLen,
  // Arbiter side.
  input wire logic grantValid,
  input wire logic [VC_W-1:0] grantVc,
  output logic [NUM_VC-1:0] chReady,
  output logic [NUM_VC-1:0][LEN_W-1:0] chLen,
  output logic lastWord,
  output logic [LEN_W-1:0] lastLen
);
  logic [3:0] gap; // Cycles left in the frame on the link.
  // A buffer stays ready until its frame is granted, as a full or closed buffer would.
  // Cold reset empties the buffers and drops any frame still on the link.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chReady <= '0;
      lastWord <= 1'b0;
      gap <= '0;
    end else begin
      lastWord <= 1'b0;
      if (load) begin
        chReady <= newReady;
      end
      if (grantValid) begin
        chReady[grantVc] <= 1'b0;
        gap <= 4'h4;
      end else if (gap != 4'h0) begin
        gap <= gap - 4'h1;
        lastWord <= (gap == 4'h1);
      end
    end
  end
  // The length is only meaningful with lastWord, so it is scrambled otherwise.
  assign chLen = {NUM_VC{frameLen}};
  assign lastLen = lastWord ? frameLen : ~frameLen;
endmodule
`default_nettype wire

/* File: bench/virtual_channel_frame_arbiter_tb.sv */
// Purpose: Self-checking bench for the frame arbiter.
// Assumes: Frames of 256 characters and default shares of 0x20.
// Notes: Each frame adds 256 to idle channels and takes 1792 from the sender.
`timescale 1ns/10ps
`default_nettype none
module virtual_channel_frame_arbiter_tb
  import vc_arb_pkg::*;
;
  logic ref_clk = 1'b0; // Bench clock.
  logic nrst = 1'b0; // Cold reset.
  logic warmRst = 1'b0; // Warm reset.
  reg_req_t regReq = '0; // Register request.
  logic [31:0] regRdata;
  logic [NUM_VC-1:0] chReady;
  logic [NUM_VC-1:0][LEN_W-1:0] chLen;
  logic [NUM_VC-1:0][FCT_W-1:0] fctCredit = '1; // Far-end room per channel.
  logic lastWord;
  logic [LEN_W-1:0] lastLen;
  logic [SLOT_W-1:0] slotNum = '0; // Current time-slot.
  logic grantValid;
  logic [VC_W-1:0] grantVc;
  logic [NUM_VC-1:0] underUse;
  logic [NUM_VC-1:0] overUse;
  logic load = 1'b0; // Loads the model's ready mask.
  logic [NUM_VC-1:0] newReady = '0;
  logic [LEN_W-1:0] frameLen = 9'h100; // Full frames.
  int failures = 0;
  int n_compared = 0;

  // The clock toggles every half period of 5 ns.
  always #5 ref_clk = ~ref_clk;

  vc_frame_arbiter i_dut (.ref_clk(ref_clk), .nrst(nrst), .warmRst(warmRst), .regReq(regReq),
    .regRdata(regRdata), .chReady(chReady), .chLen(chLen), .fctCredit(fctCredit),
    .lastWord(lastWord), .lastLen(lastLen), .slotNum(slotNum), .grantValid(grantValid),
    .grantVc(grantVc), .underUse(underUse), .overUse(overUse));

  vc_chan_model i_model (.ref_clk(ref_clk), .nrst(nrst), .load(load), .newReady(newReady), .frameLen(frameLen),
    .grantValid(grantValid), .grantVc(grantVc), .chReady(chReady), .chLen(chLen),
    .lastWord(lastWord), .lastLen(lastLen));

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One register write strobe.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regReq.addr <= a;
    regReq.wdata <= d;
    regReq.wr <= 1'b1;
    @(posedge ref_clk);
    regReq.wr <= 1'b0;
  endtask

  // One register read; data is looked at in the cycle after the strobe.
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regReq.addr <= a;
    regReq.rd <= 1'b1;
    @(posedge ref_clk);
    regReq.rd <= 1'b0;
    #1;
    check(regRdata, exp);
  endtask

  // Gives the marked channels one frame each.
  task automatic load_ready(input logic [NUM_VC-1:0] m);
    @(posedge ref_clk);
    load <= 1'b1;
    newReady <= m;
    @(posedge ref_clk);
    load <= 1'b0;
    #1;
  endtask

  // Waits a bounded time for a grant and checks the channel.
  task automatic expect_grant(input logic [VC_W-1:0] vc);
    int i;
    i = 0;
    while (grantValid !== 1'b1 && i < 40) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    check({28'h000_0000, grantValid, grantVc}, {28'h000_0000, 1'b1, vc});
    @(posedge ref_clk);
    #1;
  endtask

  // Checks that no grant appears for n cycles.
  task automatic expect_none(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      seen = seen | (grantValid !== 1'b0);
    end
    check({31'h0000_0000, seen}, 32'h0000_0000);
  endtask

  // Lets running frames finish, then applies a cold reset for five cycles.
  task automatic do_reset();
    if (nrst) begin
      repeat (8) @(posedge ref_clk);
    end
    nrst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // Reset values of the registers and an unmapped read.
  task automatic t_reset_values();
    reg_rd(ADDR_LIMIT, 32'h0000_1000);
    reg_rd(CFG_BASE, 32'h0000_20F0);
    reg_rd(CREDIT_BASE + 8'h1C, 32'h0000_0000);
    reg_rd(8'h10, 32'h0000_0000);
  endtask

  // Best-effort ranking by credit, ties, accumulation and warm reset.
  task automatic t_best_effort();
    load_ready(8'h60);
    expect_grant(3'h5);
    expect_grant(3'h6);
    repeat (8) @(posedge ref_clk);
    load_ready(8'h61);
    expect_grant(3'h0);
    expect_grant(3'h5);
    expect_grant(3'h6);
    repeat (8) @(posedge ref_clk);
    reg_rd(CREDIT_BASE + 8'h04, 32'h0000_0500);
    reg_rd(CREDIT_BASE + 8'h14, 32'hFFFF_F500);
    reg_rd(CREDIT_BASE, 32'hFFFF_FD00);
    expect_none(6);
    reg_rd(CREDIT_BASE, 32'hFFFF_FD00);
    @(posedge ref_clk);
    warmRst <= 1'b1;
    load_ready(8'h02);
    expect_none(4);
    @(posedge ref_clk);
    warmRst <= 1'b0;
    expect_grant(3'h1);
    repeat (8) @(posedge ref_clk);
    reg_rd(CREDIT_BASE, 32'hFFFF_FE00);
  endtask

  // Priority levels 1, 7, 9 and 15 against a reserved channel and best effort.
  task automatic t_priority();
    reg_wr(CFG_BASE + 8'h0C, 32'h0000_2011);
    reg_wr(CFG_BASE + 8'h08, 32'h0000_20F1);
    reg_wr(CFG_BASE + 8'h04, 32'h0000_2071);
    reg_wr(CFG_BASE + 8'h1C, 32'h0000_2091);
    reg_wr(CFG_BASE + 8'h18, 32'h0000_2002);
    reg_rd(CFG_BASE + 8'h0C, 32'h0000_2011);
    load_ready(8'hDE);
    expect_grant(3'h3);
    expect_grant(3'h1);
    expect_grant(3'h6);
    expect_grant(3'h7);
    expect_grant(3'h2);
    expect_grant(3'h4);
  endtask

  // Scheduled channel blocked off-slot, yielding its slot, then sending.
  task automatic t_sched();
    reg_wr(CFG_BASE + 8'h14, 32'h0200_2003);
    load_ready(8'h20);
    expect_none(8);
    @(posedge ref_clk);
    fctCredit[5] <= 16'h00FF;
    slotNum <= 3'h1;
    load_ready(8'h30);
    expect_grant(3'h4);
    @(posedge ref_clk);
    fctCredit[5] <= 16'h0100;
    load_ready(8'h28);
    expect_grant(3'h5);
    expect_grant(3'h3);
  endtask

  // Clamping and usage flags with a small credit limit.
  task automatic t_saturate();
    reg_wr(ADDR_LIMIT, 32'h0000_0200);
    reg_rd(ADDR_LIMIT, 32'h0000_0200);
    load_ready(8'h01);
    expect_grant(3'h0);
    repeat (8) @(posedge ref_clk);
    load_ready(8'h01);
    expect_grant(3'h0);
    repeat (8) @(posedge ref_clk);
    reg_rd(CREDIT_BASE, 32'hFFFF_FE00);
    reg_rd(CREDIT_BASE + 8'h04, 32'h0000_0200);
    check({16'h0000, overUse, underUse}, 32'h0000_01FE);
    reg_rd(ADDR_STATUS, 32'h0000_01FE);
    reg_wr(ADDR_STATUS, 32'h0000_FFFF);
    reg_rd(ADDR_STATUS, 32'h0000_0000);
  endtask

  // Stops a hung run well after the tests should have ended.
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    do_reset();
    t_reset_values();
    t_best_effort();
    do_reset();
    t_priority();
    t_sched();
    do_reset();
    t_saturate();
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: rtl/vc_arb_pkg.sv */
// Purpose: Shared constants and types for the frame arbiter.
// Assumes: Eight channels, frames of up to 256 characters.
// Notes: Credits are in characters, signed, two's complement.
package vc_arb_pkg;
  // Channel count and derived widths.
  localparam int NUM_VC = 8;
  localparam int VC_W = 3;
  localparam int LEN_W = 9;
  localparam int FCT_W = 16;
  localparam int SLOT_W = 3;
  // Credit limit, stored credit and precedence widths.
  localparam int LIM_W = 24;
  localparam int CR_W = 26;
  localparam int PR_W = 28;
  // Priority levels: mid level, span per side, lowest level.
  localparam int PRIO_MID = 8;
  localparam int PRIO_SPAN = 7;
  localparam logic [3:0] PRIO_TOP = 4'h1;
  localparam logic [3:0] PRIO_LOW = 4'hF;
  // Register byte addresses.
  localparam logic [7:0] ADDR_LIMIT = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] CFG_BASE = 8'h20;
  localparam logic [7:0] CREDIT_BASE = 8'h40;
  // Per-channel config word layout.
  localparam int QOS_LSB = 0;
  localparam int PRIO_LSB = 4;
  localparam int SHARE_LSB = 8;
  localparam int MASK_LSB = 24;
  // Status word layout.
  localparam int OVER_LSB = 8;
  // Reset values: share 1/N of 256, default credit limit.
  localparam logic [7:0] SHARE_RESET = 8'h20;
  localparam logic [LIM_W-1:0] LIMIT_RESET = 24'h00_1000;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // Quality of service classes.
  typedef enum logic [1:0] {
    QOS_BE, QOS_PRIO, QOS_BWRES, QOS_SCHED
  } qos_t;
  // Arbiter phase.
  typedef enum logic {ARB_IDLE, ARB_BUSY} arb_state_t;
  // One channel's configuration.
  typedef struct packed {
    logic [7:0] slotMask;
    logic [7:0] share;
    logic [3:0] prio;
    qos_t qos;
  } chan_cfg_t;
  // Software register port.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  // Whole module state.
  typedef struct packed {
    arb_state_t fsm;
    logic [VC_W-1:0] curVc;
    logic grantValid;
    logic [VC_W-1:0] grantVc;
    logic [LIM_W-1:0] limit;
    logic [NUM_VC-1:0] under;
    logic [NUM_VC-1:0] over;
    chan_cfg_t [NUM_VC-1:0] cfg;
    logic [NUM_VC-1:0][CR_W-1:0] credit;
    logic [31:0] rdata;
  } state_t;
endpackage

/* File: rtl/vc_frame_arbiter.sv */
// Purpose: Picks the virtual channel that sends the next data frame.
// Assumes: Channel buffers and framing layer share ref_clk.
// Notes: Credits survive warm reset; only nrst clears them.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Only frame-ready channels compete.
// - Exclude channels lacking far-end room.
// - Decide at last word of frame.
// - Highest precedence ready channel wins.
// - Precedence comes from class and parameters.
// - Best effort loses to any other class.
// - Best effort ranks by bandwidth credit.
// - Priority level gives fixed precedence.
// - Reserved precedence follows bandwidth credit.
// - Scheduled channel maximal in its slot.
// - Scheduled channel blocked outside its slots.
// - Idle slot capacity goes to others.
// - Every channel holds an expected share.
// - Used amount is sender's frame length.
// - Allowance is share times last frame.
// - Credit accumulates allowance minus used, over share.
// - Credits update per frame, else frozen.
// - Signed credit clamps at both limits.
// - Credit limit equals link bandwidth value.
// - Positive limit sets under-use flag.
// - Negative limit sets over-use flag.
// - Cold reset clears credits, warm keeps.
// - Sendable when flow credit covers frame.
// - Fifteen priority levels spaced across limits.
module vc_frame_arbiter
  import vc_arb_pkg::*;
(
  // Clock and resets.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic warmRst,
  // Software register port.
  input wire reg_req_t regReq,
  output logic [31:0] regRdata,
  // Channel buffers.
  input wire logic [NUM_VC-1:0] chReady,
  input wire logic [NUM_VC-1:0][LEN_W-1:0] chLen,
  input wire logic [NUM_VC-1:0][FCT_W-1:0] fctCredit,
  // Framing layer and time-slot source.
  input wire logic lastWord,
  input wire logic [LEN_W-1:0] lastLen,
  input wire logic [SLOT_W-1:0] slotNum,
  // Grant and usage flags.
  output logic grantValid,
  output logic [VC_W-1:0] grantVc,
  output logic [NUM_VC-1:0] underUse,
  output logic [NUM_VC-1:0] overUse
);

  // Reset release pipeline and its output.
  logic [1:0] rstPipe;
  logic rstN;
  // Registered and next state.
  state_t s;
  state_t n;
  // Arbitration helpers.
  logic [NUM_VC-1:0] elig;
  logic anyElig;
  logic anyNonBe;
  logic signed [PR_W-1:0] prec [NUM_VC];
  logic [VC_W-1:0] winner;
  logic decide;
  logic frameEnd;
  // Credit update helpers.
  logic signed [CR_W-1:0] newCr [NUM_VC];
  logic [NUM_VC-1:0] hitHi;
  logic [NUM_VC-1:0] hitLo;

  // Zero-extended credit limit, as a signed value.
  function automatic logic signed [PR_W-1:0] limExt(
    input logic [LIM_W-1:0] l);
    return signed'({{(PR_W-LIM_W){1'b0}}, l});
  endfunction

  // Precedence of one channel from class and credit.
  function automatic logic signed [PR_W-1:0] precOf(
    input chan_cfg_t c, input logic [CR_W-1:0] cr,
    input logic [LIM_W-1:0] lim, input logic nonBe);
    logic signed [PR_W-1:0] l;
    logic signed [PR_W-1:0] p;
    logic signed [PR_W-1:0] k;
    logic [3:0] lvl;
    l = limExt(lim);
    p = '0;
    lvl = (c.prio == 4'h0) ? PRIO_LOW : c.prio;
    k = PR_W'(PRIO_MID) - signed'({{(PR_W-4){1'b0}}, lvl});
    case (c.qos)
      QOS_BE: begin
        // Sits below the lowest priority level when others wait.
        p = nonBe ? (-l - PR_W'(2)) : PR_W'(signed'(cr));
      end
      QOS_PRIO: begin
        // Levels spread evenly; ends just outside the limits.
        p = PR_W'((k * l) / PR_W'(PRIO_SPAN));
        if (lvl == PRIO_TOP) begin
          p = l + PR_W'(1);
        end else if (lvl == PRIO_LOW) begin
          p = -l - PR_W'(1);
        end
      end
      QOS_BWRES: begin
        // Falls as the channel sends, recovers as others send.
        p = PR_W'(signed'(cr));
      end
      QOS_SCHED: begin
        // Also computed off-slot; eligibility then keeps the channel out.
        p = l + PR_W'(2);
      end
      default: begin
        p = '0;
      end
    endcase
    return p;
  endfunction

  // Used characters scaled by 256 over share (restoring divide).
  function automatic logic [CR_W-1:0] usedScaled(
    input logic [LEN_W-1:0] used, input logic [7:0] share);
    logic [LEN_W+7:0] num;
    logic [9:0] den;
    logic [9:0] rem;
    logic [LEN_W+7:0] q;
    num = {used, 8'h00};
    den = (share == 8'h00) ? 10'h001 : {2'b00, share};
    rem = '0;
    q = '0;
    for (int b = LEN_W + 7; b >= 0; b--) begin
      rem = {rem[8:0], num[b]};
      if (rem >= den) begin
        rem = rem - den;
        q[b] = 1'b1;
      end
    end
    return CR_W'(q);
  endfunction

  // True when the address falls in a per-channel block.
  function automatic logic inBlock(
    input logic [7:0] a, input logic [7:0] base);
    return a[7:VC_W+2] == base[7:VC_W+2];
  endfunction

  // Two flip-flops release the reset synchronously.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  // Eligibility, precedence and winner selection.
  always_comb begin
    logic signed [PR_W-1:0] bestP;
    logic signed [CR_W-1:0] bestC;
    bestP = '0;
    bestC = '0;
    anyElig = 1'b0;
    anyNonBe = 1'b0;
    winner = '0;
    for (int i = 0; i < NUM_VC; i++) begin
      // Ready, covered by flow credit, and inside its slot.
      elig[i] = chReady[i]
        && (fctCredit[i] >= FCT_W'(chLen[i]))
        && (s.cfg[i].qos != QOS_SCHED
            || s.cfg[i].slotMask[slotNum]);
      if (elig[i] && s.cfg[i].qos != QOS_BE) begin
        anyNonBe = 1'b1;
      end
    end
    for (int i = 0; i < NUM_VC; i++) begin
      prec[i] = precOf(s.cfg[i], s.credit[i], s.limit, anyNonBe);
      // Strict compare keeps the lowest index on a full tie.
      if (elig[i] && (!anyElig || prec[i] > bestP
          || (prec[i] == bestP
              && signed'(s.credit[i]) > bestC))) begin
        anyElig = 1'b1;
        bestP = prec[i];
        bestC = signed'(s.credit[i]);
        winner = VC_W'(i);
      end
    end
    // A new grant is decided when idle or at the final word.
    decide = anyElig && !warmRst
      && (s.fsm == ARB_IDLE
          || (s.fsm == ARB_BUSY && lastWord));
    frameEnd = (s.fsm == ARB_BUSY) && lastWord;
  end

  // Credit arithmetic for the frame that just finished.
  always_comb begin
    logic signed [CR_W-1:0] l;
    logic signed [CR_W-1:0] sum;
    logic [CR_W-1:0] sub;
    l = signed'({{(CR_W-LIM_W){1'b0}}, s.limit});
    sum = '0;
    sub = '0;
    for (int i = 0; i < NUM_VC; i++) begin
      // Allowance minus used, over share: L - used*256/share.
      sub = (VC_W'(i) == s.curVc)
        ? usedScaled(lastLen, s.cfg[i].share) : '0;
      sum = signed'(s.credit[i]) + CR_W'(lastLen)
        - signed'(sub);
      hitHi[i] = sum >= l;
      hitLo[i] = sum <= -l;
      // Clamp instead of running past either bound.
      if (hitHi[i]) begin
        newCr[i] = l;
      end else if (hitLo[i]) begin
        newCr[i] = -l;
      end else begin
        newCr[i] = sum;
      end
    end
  end

  // Next state: grant phase, credits, flags and registers.
  always_comb begin
    logic [NUM_VC-1:0] clrUnder;
    logic [NUM_VC-1:0] clrOver;
    logic [VC_W-1:0] idx;
    n = s;
    n.grantValid = 1'b0;
    n.rdata = '0;
    clrUnder = '0;
    clrOver = '0;
    idx = regReq.addr[VC_W+1:2];
    // Grant phase.
    case (s.fsm)
      ARB_IDLE: begin
        if (decide) begin
          n.fsm = ARB_BUSY;
        end
      end
      ARB_BUSY: begin
        if (lastWord && !decide) begin
          n.fsm = ARB_IDLE;
        end
      end
      default: begin
        n.fsm = ARB_IDLE;
      end
    endcase
    if (decide) begin
      n.grantValid = 1'b1;
      n.grantVc = winner;
      n.curVc = winner;
    end
    if (warmRst) begin
      n.fsm = ARB_IDLE;
    end
    // Software writes.
    if (regReq.wr) begin
      if (regReq.addr == ADDR_LIMIT) begin
        n.limit = regReq.wdata[LIM_W-1:0];
      end else if (regReq.addr == ADDR_STATUS) begin
        // Write one to clear a flag.
        clrUnder = regReq.wdata[NUM_VC-1:0];
        clrOver = regReq.wdata[OVER_LSB+NUM_VC-1:OVER_LSB];
      end else if (inBlock(regReq.addr, CFG_BASE)) begin
        n.cfg[idx].qos = qos_t'(regReq.wdata[QOS_LSB+1:QOS_LSB]);
        n.cfg[idx].prio = regReq.wdata[PRIO_LSB+3:PRIO_LSB];
        n.cfg[idx].share = regReq.wdata[SHARE_LSB+7:SHARE_LSB];
        n.cfg[idx].slotMask = regReq.wdata[MASK_LSB+7:MASK_LSB];
      end
    end
    // Credits move only when a frame has finished.
    if (frameEnd) begin
      for (int i = 0; i < NUM_VC; i++) begin
        n.credit[i] = newCr[i];
      end
    end
    // Sticky flags; a new hit beats a clear.
    n.under = (s.under & ~clrUnder)
      | (frameEnd ? hitHi : '0);
    n.over = (s.over & ~clrOver)
      | (frameEnd ? hitLo : '0);
    // Software reads, answered in the next cycle.
    if (regReq.rd) begin
      if (regReq.addr == ADDR_LIMIT) begin
        n.rdata = 32'(s.limit);
      end else if (regReq.addr == ADDR_STATUS) begin
        n.rdata = 32'({s.over, s.under});
      end else if (inBlock(regReq.addr, CFG_BASE)) begin
        n.rdata = {s.cfg[idx].slotMask, 8'h00, s.cfg[idx].share,
          s.cfg[idx].prio, 2'b00, s.cfg[idx].qos};
      end else if (inBlock(regReq.addr, CREDIT_BASE)) begin
        n.rdata = 32'(signed'(s.credit[idx]));
      end
    end
  end

  // State register; cold reset sets every field.
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      s.fsm <= ARB_IDLE;
      s.curVc <= '0;
      s.grantValid <= 1'b0;
      s.grantVc <= '0;
      s.limit <= LIMIT_RESET;
      s.under <= '0;
      s.over <= '0;
      for (int i = 0; i < NUM_VC; i++) begin
        s.cfg[i].qos <= QOS_BE;
        s.cfg[i].prio <= PRIO_LOW;
        s.cfg[i].share <= SHARE_RESET;
        s.cfg[i].slotMask <= MASK_RESET;
      end
      s.credit <= '0;
      s.rdata <= '0;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register.
  assign grantValid = s.grantValid;
  assign grantVc = s.grantVc;
  assign regRdata = s.rdata;
  assign underUse = s.under;
  assign overUse = s.over;

  // Checks on the arbitration and credit logic.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  a_win_ready: assert property (decide |-> chReady[winner])
    else $error("Grant to a channel that is not ready.");
  a_win_room: assert property (
    decide |-> fctCredit[winner] >= FCT_W'(chLen[winner]))
    else $error("Grant without far-end room.");
  a_decide_when: assert property (
    s.fsm == ARB_BUSY && !lastWord |-> !decide)
    else $error("Grant decided mid frame.");
  a_grant_out: assert property (
    decide |=> grantValid && grantVc == $past(winner))
    else $error("Grant output does not follow decision.");
  a_be_yields: assert property (
    decide && anyNonBe |-> s.cfg[winner].qos != QOS_BE)
    else $error("Best effort won over another class.");
  a_sched_slot: assert property (decide && s.cfg[winner].qos
    == QOS_SCHED |-> s.cfg[winner].slotMask[slotNum])
    else $error("Scheduled channel sent outside its slot.");
  a_credit_frozen: assert property (
    !frameEnd |=> s.credit == $past(s.credit))
    else $error("Credit changed with no frame sent.");
  a_credit_bound: assert property (
    signed'(s.credit[0]) <= signed'(CR_W'(s.limit))
    && signed'(s.credit[0]) >= -signed'(CR_W'(s.limit)))
    else $error("Credit outside its limits.");
  // Every channel that hits a limit shows its flag next cycle; a clear cannot hide it.
  a_under_set: assert property (
    frameEnd && (hitHi != '0) |=> (underUse & $past(hitHi)) == $past(hitHi))
    else $error("Under-use flag not set at positive limit.");
  a_over_set: assert property (
    frameEnd && (hitLo != '0) |=> (overUse & $past(hitLo)) == $past(hitLo))
    else $error("Over-use flag not set at negative limit.");

  c_sched_grant: cover property (
    decide && s.cfg[winner].qos == QOS_SCHED);
  c_be_grant: cover property (decide && !anyNonBe);
  c_back_to_back: cover property (decide ##[1:8] decide);
  c_saturate: cover property (frameEnd && (hitHi != '0));

endmodule

`default_nettype wire
